// ---- src/pmic_led_irq_map.svh ----
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the register bank only
`ifndef PMIC_LED_IRQ_MAP_SVH
`define PMIC_LED_IRQ_MAP_SVH

// register indices; byte address is four times the index
`define IDX_CHIP_IDENTITY 6'h00
`define IDX_CONFIG_VARIANT 6'h01
`define IDX_SILICON_REVISION 6'h02
`define IDX_IRQ_GROUP_SUMMARY 6'h06
`define IDX_BUCK_LOW_LIMIT_STATUS 6'h08
`define IDX_BUCK_LOW_LIMIT_MASK 6'h09
`define IDX_BUCK_LOW_LIMIT_LIVE 6'h0A
`define IDX_BUCK_HIGH_LIMIT_STATUS 6'h0B
`define IDX_BUCK_HIGH_LIMIT_MASK 6'h0C
`define IDX_BUCK_HIGH_LIMIT_LIVE 6'h0D
`define IDX_BUCK_RAMP_DONE_STATUS 6'h0E
`define IDX_BUCK_RAMP_DONE_MASK 6'h0F
`define IDX_BUCK_RAMP_DONE_LIVE 6'h10
`define IDX_INDICATOR_CONFIG 6'h1E
`define IDX_CHARGER_KEY_TWO 6'h1F

// indicator configuration fields
`define POS_BLINK_RATE_SEL 0
`define POS_DRIVE_LEVEL 2
`define POS_PATTERN_SEL 4
`define POS_SW_OVERRIDE 5
`define RW1S_BITS_INDICATOR 8'h1C

// summary bit positions
`define POS_CHARGER_GROUP 0
`define POS_BUCK1_GROUP 1
`define POS_BUCK2_GROUP 2
`define POS_BUCK3_GROUP 3
`define POS_LINREG_GROUP 4
`define POS_KEY_GROUP 5
`define POS_THERMAL_GROUP 6
`define POS_MISC_GROUP 7

// reset values
`define RST_LIMIT_MASK 3'h7
`define RST_RAMP_MASK 2'h3
`define RST_INDICATOR_CONFIG 8'h00
`define RST_CHARGER_KEY_TWO 8'h00

// blink timing: clock rate and rates in hundredths of a hertz
`define CLK_HZ 64'd250000000
`define RATE_CODE0_CHZ 64'd100
`define RATE_CODE1_CHZ 64'd150
`define RATE_CODE2_CHZ 64'd25600
`define RATE_CODE3_CHZ 64'd800
`define HALF_PERIOD_CYCLES(f) ((`CLK_HZ * 64'd100) / (64'd2 * (f)))

`endif

// ---- src/pmic_led_irq_pkg.sv ----
// types shared by the register bank and its surroundings
// assumes nothing beyond the map header
package pmic_led_irq_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_type;

	typedef struct packed {
		logic charging;
		logic fault;
		logic done;
	} charger_state_type;

	typedef struct packed {
		logic [2:0] low;
		logic [2:0] high;
		logic [1:0] ramp;
	} buck_sense_type;

	typedef struct packed {
		logic misc;
		logic thermal;
		logic key;
		logic linreg;
		logic charger;
	} other_groups_type;

	typedef struct packed {
		logic [2:0] stat_low;
		logic [2:0] stat_high;
		logic [1:0] stat_ramp;
		logic [2:0] mask_low;
		logic [2:0] mask_high;
		logic [1:0] mask_ramp;
		buck_sense_type live;
		logic [7:0] indicator_pattern_sel;
		logic [7:0] key2;
		logic [26:0] blink_cnt;
		logic blink;
		logic indicator_on;
		logic [1:0] drive_level;
		logic [31:0] prdata;
		logic rd_loaded;
		logic [7:0] summary;
	} state_type;

endpackage

// ---- src/pmic_led_and_irq_regs.sv ----
// indicator configuration and buck interrupt register bank on apb
// assumes all inputs synchronous to pclk; resets other than presetn are levels
`timescale 1ns/100ps
`include "pmic_led_irq_map.svh"

module pmic_led_and_irq_regs #(
	parameter logic [7:0] CHIP_IDENTITY = 8'h5A, // arbitrary value
	parameter logic [7:0] CONFIG_VARIANT = 8'h00, // arbitrary value
	parameter logic [7:0] SILICON_REVISION = 8'h11, // arbitrary value
	parameter int unsigned HALF_CODE0 = 32'(`HALF_PERIOD_CYCLES(`RATE_CODE0_CHZ)),
	parameter int unsigned HALF_CODE1 = 32'(`HALF_PERIOD_CYCLES(`RATE_CODE1_CHZ)),
	parameter int unsigned HALF_CODE2 = 32'(`HALF_PERIOD_CYCLES(`RATE_CODE2_CHZ)),
	parameter int unsigned HALF_CODE3 = 32'(`HALF_PERIOD_CYCLES(`RATE_CODE3_CHZ))
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic core_domain_reset,
	input wire logic power_on_reset_n,
	input wire logic host_reset_n,
	input wire logic regs_off_pulse,
	input wire pmic_led_irq_pkg::apb_req_type apb_req,
	output pmic_led_irq_pkg::apb_rsp_type apb_rsp,
	input wire pmic_led_irq_pkg::buck_sense_type buck_sense,
	input wire pmic_led_irq_pkg::other_groups_type other_groups,
	input wire pmic_led_irq_pkg::charger_state_type charger_state,
	output logic indicator_on,
	output logic [1:0] indicator_drive_level,
	output logic [7:0] irq_group_summary
);

	pmic_led_irq_pkg::state_type cur;
	pmic_led_irq_pkg::state_type next_state;

	logic [5:0] idx;
	logic setup;
	logic access;
	logic wr;
	logic mapped;
	logic [26:0] half_sel;
	logic [7:0] summary;
	logic [7:0] rd;
	logic [7:0] w8;
	logic [2:0] rise_low;
	logic [2:0] rise_high;
	logic [1:0] rise_ramp;
	logic [2:0] pend_low;
	logic [2:0] pend_high;
	logic [1:0] pend_ramp;
	logic blink_wrap;
	logic charger_wave;
	logic irq_domain_clear;
	logic quiet;
	logic rd_ready;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign idx = apb_req.paddr[7:2];
	assign setup = apb_req.psel & ~apb_req.penable;
	assign access = apb_req.psel & apb_req.penable;
	assign wr = access & apb_req.pwrite & ce;
	assign w8 = apb_req.pwdata[7:0];

	always_comb begin
		mapped = 1'b0;
		case (idx)
			`IDX_CHIP_IDENTITY, `IDX_CONFIG_VARIANT, `IDX_SILICON_REVISION,
			`IDX_IRQ_GROUP_SUMMARY, `IDX_BUCK_LOW_LIMIT_STATUS,
			`IDX_BUCK_LOW_LIMIT_MASK, `IDX_BUCK_LOW_LIMIT_LIVE,
			`IDX_BUCK_HIGH_LIMIT_STATUS, `IDX_BUCK_HIGH_LIMIT_MASK,
			`IDX_BUCK_HIGH_LIMIT_LIVE, `IDX_BUCK_RAMP_DONE_STATUS,
			`IDX_BUCK_RAMP_DONE_MASK, `IDX_BUCK_RAMP_DONE_LIVE,
			`IDX_INDICATOR_CONFIG, `IDX_CHARGER_KEY_TWO: begin
				mapped = (apb_req.paddr[1:0] == 2'h0);
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// zero-wait slave; a read whose setup edge was frozen by the clock
	// enable waits one enabled edge to fetch its data
	assign rd_ready = apb_req.pwrite | cur.rd_loaded;
	assign apb_rsp.pready = ce & rd_ready;
	assign apb_rsp.pslverr = access & ~mapped;
	assign apb_rsp.prdata = cur.prdata;

	// ----------------------------------------------------------------
	// interrupt summary
	// ----------------------------------------------------------------
	assign pend_low = cur.stat_low & ~cur.mask_low;
	assign pend_high = cur.stat_high & ~cur.mask_high;
	assign pend_ramp = cur.stat_ramp & ~cur.mask_ramp;

	always_comb begin
		summary = 8'h00;
		summary[`POS_CHARGER_GROUP] = other_groups.charger;
		summary[`POS_BUCK1_GROUP] = pend_low[0] | pend_high[0] | pend_ramp[0];
		summary[`POS_BUCK2_GROUP] = pend_low[1] | pend_high[1] | pend_ramp[1];
		summary[`POS_BUCK3_GROUP] = pend_low[2] | pend_high[2];
		summary[`POS_LINREG_GROUP] = other_groups.linreg;
		summary[`POS_KEY_GROUP] = other_groups.key;
		summary[`POS_THERMAL_GROUP] = other_groups.thermal;
		summary[`POS_MISC_GROUP] = other_groups.misc;
	end

	assign irq_group_summary = cur.summary;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		case (idx)
			`IDX_CHIP_IDENTITY: rd = CHIP_IDENTITY;
			`IDX_CONFIG_VARIANT: rd = CONFIG_VARIANT;
			`IDX_SILICON_REVISION: rd = SILICON_REVISION;
			`IDX_IRQ_GROUP_SUMMARY: rd = summary;
			`IDX_BUCK_LOW_LIMIT_STATUS: rd = {5'h00, cur.stat_low};
			`IDX_BUCK_LOW_LIMIT_MASK: rd = {5'h00, cur.mask_low};
			`IDX_BUCK_LOW_LIMIT_LIVE: rd = {5'h00, cur.live.low};
			`IDX_BUCK_HIGH_LIMIT_STATUS: rd = {5'h00, cur.stat_high};
			`IDX_BUCK_HIGH_LIMIT_MASK: rd = {5'h00, cur.mask_high};
			`IDX_BUCK_HIGH_LIMIT_LIVE: rd = {5'h00, cur.live.high};
			`IDX_BUCK_RAMP_DONE_STATUS: rd = {6'h00, cur.stat_ramp};
			`IDX_BUCK_RAMP_DONE_MASK: rd = {6'h00, cur.mask_ramp};
			`IDX_BUCK_RAMP_DONE_LIVE: rd = {6'h00, cur.live.ramp};
			`IDX_INDICATOR_CONFIG: rd = cur.indicator_pattern_sel;
			`IDX_CHARGER_KEY_TWO: rd = cur.key2;
			default: rd = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// blink rate and charger pattern
	// ----------------------------------------------------------------
	always_comb begin
		case (cur.indicator_pattern_sel[`POS_BLINK_RATE_SEL +: 2])
			2'h0: half_sel = 27'(HALF_CODE0);
			2'h1: half_sel = 27'(HALF_CODE1);
			2'h2: half_sel = 27'(HALF_CODE2);
			2'h3: half_sel = 27'(HALF_CODE3);
			default: half_sel = 27'(HALF_CODE0);
		endcase
	end

	// >= so a shorter rate chosen mid-count wraps at once
	assign blink_wrap = (cur.blink_cnt >= half_sel - 27'h1);

	always_comb begin
		charger_wave = 1'b0;
		if (charger_state.done) begin
			charger_wave = 1'b0;
		end else if (charger_state.fault) begin
			charger_wave = cur.indicator_pattern_sel[`POS_PATTERN_SEL] ? 1'b1 : cur.blink;
		end else if (charger_state.charging) begin
			charger_wave = cur.indicator_pattern_sel[`POS_PATTERN_SEL] ? cur.blink : 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	assign rise_low = buck_sense.low & ~cur.live.low;
	assign rise_high = buck_sense.high & ~cur.live.high;
	assign rise_ramp = buck_sense.ramp & ~cur.live.ramp;
	assign irq_domain_clear = ~power_on_reset_n | ~host_reset_n;

	always_comb begin
		next_state = cur;
		next_state.live = buck_sense;
		// set wins over a clearing write in the same cycle
		next_state.stat_low = (cur.stat_low
			& ~((wr && idx == `IDX_BUCK_LOW_LIMIT_STATUS) ? w8[2:0] : 3'h0))
			| rise_low;
		next_state.stat_high = (cur.stat_high
			& ~((wr && idx == `IDX_BUCK_HIGH_LIMIT_STATUS) ? w8[2:0] : 3'h0))
			| rise_high;
		next_state.stat_ramp = (cur.stat_ramp
			& ~((wr && idx == `IDX_BUCK_RAMP_DONE_STATUS) ? w8[1:0] : 2'h0))
			| rise_ramp;
		if (wr && idx == `IDX_BUCK_LOW_LIMIT_MASK) begin
			next_state.mask_low = w8[2:0];
		end
		if (wr && idx == `IDX_BUCK_HIGH_LIMIT_MASK) begin
			next_state.mask_high = w8[2:0];
		end
		if (wr && idx == `IDX_BUCK_RAMP_DONE_MASK) begin
			next_state.mask_ramp = w8[1:0];
		end
		if (wr && idx == `IDX_INDICATOR_CONFIG) begin
			// drive level and pattern only gain ones until reset
			next_state.indicator_pattern_sel = (w8 & ~`RW1S_BITS_INDICATOR)
				| ((cur.indicator_pattern_sel | w8) & `RW1S_BITS_INDICATOR);
		end
		if (wr && idx == `IDX_CHARGER_KEY_TWO) begin
			next_state.key2 = w8;
		end
		if (blink_wrap) begin
			next_state.blink_cnt = 27'h0;
			next_state.blink = ~cur.blink;
		end else begin
			next_state.blink_cnt = cur.blink_cnt + 27'h1;
		end
		if (cur.indicator_pattern_sel[`POS_SW_OVERRIDE]) begin
			next_state.indicator_on = cur.blink;
		end else begin
			next_state.indicator_on = charger_wave;
		end
		next_state.drive_level = cur.indicator_pattern_sel[`POS_DRIVE_LEVEL +: 2];
		if (setup) begin
			next_state.prdata = {24'h000000, rd};
			next_state.rd_loaded = 1'b1;
		end else if (access) begin
			if (rd_ready) begin
				// transfer completes at this edge
				next_state.rd_loaded = 1'b0;
			end else begin
				next_state.prdata = {24'h000000, rd};
				next_state.rd_loaded = 1'b1;
			end
		end
		if (regs_off_pulse) begin
			next_state.key2 = `RST_CHARGER_KEY_TWO;
		end
		if (irq_domain_clear) begin
			next_state.stat_low = 3'h0;
			next_state.stat_high = 3'h0;
			next_state.stat_ramp = 2'h0;
			next_state.mask_low = `RST_LIMIT_MASK;
			next_state.mask_high = `RST_LIMIT_MASK;
			next_state.mask_ramp = `RST_RAMP_MASK;
			next_state.key2 = `RST_CHARGER_KEY_TWO;
		end
		if (core_domain_reset) begin
			next_state = '0;
			next_state.mask_low = `RST_LIMIT_MASK;
			next_state.mask_high = `RST_LIMIT_MASK;
			next_state.mask_ramp = `RST_RAMP_MASK;
			next_state.indicator_pattern_sel = `RST_INDICATOR_CONFIG;
			// keep tracking live levels so no false edge follows
			next_state.live = buck_sense;
		end
		next_state.summary = summary;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
			cur.mask_low <= `RST_LIMIT_MASK;
			cur.mask_high <= `RST_LIMIT_MASK;
			cur.mask_ramp <= `RST_RAMP_MASK;
		end else if (ce) begin
			cur <= next_state;
		end
	end

	assign indicator_on = cur.indicator_on;
	assign indicator_drive_level = cur.drive_level;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	assign quiet = ce & ~core_domain_reset & ~irq_domain_clear & ~regs_off_pulse;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_led_write;
		wr && idx == `IDX_INDICATOR_CONFIG && quiet;
	endsequence

	sequence s_summary_setup;
		setup && ce && idx == `IDX_IRQ_GROUP_SUMMARY;
	endsequence

	sequence s_buck1_unmasked_event;
		quiet && rise_low[0] && !cur.mask_low[0] && !wr;
	endsequence

	a_blink_rate_wrap: assert property (
		(quiet && blink_wrap) |=> ($changed(cur.blink) && cur.blink_cnt == 27'h0))
		else $error("blink wave did not toggle at the selected half period");

	a_drive_level_sticky: assert property (
		s_led_write |=> ((cur.indicator_pattern_sel & `RW1S_BITS_INDICATOR)
			== (($past(cur.indicator_pattern_sel) | $past(w8)) & `RW1S_BITS_INDICATOR)) ##1
			(!$past(quiet)
			|| indicator_drive_level == $past(cur.indicator_pattern_sel[`POS_DRIVE_LEVEL +: 2])))
		else $error("drive level or pattern bits not write-one-set");

	a_pattern_done_off: assert property (
		(quiet && !cur.indicator_pattern_sel[`POS_SW_OVERRIDE] && charger_state.done) |=> !indicator_on)
		else $error("indicator lit in charge done state");

	a_pattern_steady_charge: assert property (
		(quiet && cur.indicator_pattern_sel[7:4] == 4'h0 && charger_state == 3'b100) |=> indicator_on)
		else $error("indicator not steady while charging in default pattern");

	a_override_follows_blink: assert property (
		(quiet && cur.indicator_pattern_sel[`POS_SW_OVERRIDE]) |=> (indicator_on == $past(cur.blink)))
		else $error("override did not hand indicator to software wave");

	a_core_reset_clears: assert property (
		(ce && core_domain_reset) |=> (cur.indicator_pattern_sel == 8'h00 && !indicator_on))
		else $error("indicator configuration survived core domain reset");

	a_host_reset_domain: assert property (
		(ce && irq_domain_clear && !core_domain_reset && !wr && cur.indicator_pattern_sel != 8'h00)
		|=> (cur.mask_low == `RST_LIMIT_MASK && cur.stat_low == 3'h0 && cur.indicator_pattern_sel != 8'h00))
		else $error("power-on or host reset domain misbehaved");

	a_summary_read: assert property (
		s_summary_setup |=> (apb_rsp.prdata == {24'h000000, $past(summary)}
			&& apb_rsp.pready == ce))
		else $error("summary read returned wrong value");

	a_status_set_wins: assert property (
		(quiet && rise_low != 3'h0) |=> ((cur.stat_low & $past(rise_low)) == $past(rise_low)))
		else $error("buck low limit event lost");

	a_summary_follows: assert property (
		s_buck1_unmasked_event |=> summary[`POS_BUCK1_GROUP])
		else $error("buck1 summary bit not raised by unmasked event");

	a_clock_freeze: assert property (
		!ce |=> $stable(cur))
		else $error("state moved while the clock enable was low");

	a_read_stall: assert property (
		(access && !apb_req.pwrite && !cur.rd_loaded) |-> !apb_rsp.pready)
		else $error("read completed before its data was fetched");

	a_summary_port: assert property (
		ce |=> (irq_group_summary == $past(summary)))
		else $error("summary output does not follow the group flags");

endmodule

// ---- verification/pmic_led_and_irq_regs_tb.sv ----
// self-checking bench for the indicator and buck interrupt register bank
// assumes the src/ package, map header and register bank are compiled first
`timescale 1ns/100ps

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end

module pmic_led_and_irq_regs_tb;
	logic pclk = 1'b0;
	logic presetn, ce, core_domain_reset, power_on_reset_n, host_reset_n, regs_off_pulse;
	pmic_led_irq_pkg::apb_req_type apb_req;
	pmic_led_irq_pkg::apb_rsp_type apb_rsp;
	pmic_led_irq_pkg::buck_sense_type buck_sense;
	pmic_led_irq_pkg::other_groups_type other_groups;
	pmic_led_irq_pkg::charger_state_type charger_state;
	logic indicator_on;
	logic [1:0] indicator_drive_level;
	logic [7:0] irq_group_summary;
	int err_count = 0;
	int checks_done = 0;
	int half_exp [4] = '{8, 6, 2, 4};
	logic [7:0] grp_exp [5] = '{8'h01, 8'h10, 8'h20, 8'h40, 8'h80};
	logic [5:0] rst_idx [12] = '{6'h06, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F,
		6'h10, 6'h1E, 6'h1F};
	logic [7:0] rst_val [12] = '{8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h03,
		8'h00, 8'h00, 8'h00};

	always #2 pclk = ~pclk;

	// bounds the whole run
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		$display("unexpected at %0t: run did not finish", $time);
		results();
	end

	pmic_led_and_irq_regs #(.HALF_CODE0(8), .HALF_CODE1(6), .HALF_CODE2(2), .HALF_CODE3(4)) uut (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.core_domain_reset(core_domain_reset),
		.power_on_reset_n(power_on_reset_n),
		.host_reset_n(host_reset_n),
		.regs_off_pulse(regs_off_pulse),
		.apb_req(apb_req),
		.apb_rsp(apb_rsp),
		.buck_sense(buck_sense),
		.other_groups(other_groups),
		.charger_state(charger_state),
		.indicator_on(indicator_on),
		.indicator_drive_level(indicator_drive_level),
		.irq_group_summary(irq_group_summary)
	);

	// ----------------------------------------
	// bus tasks and observers
	// ----------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// entered right after a rising edge; leaves one idle cycle behind
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
		output logic [7:0] rd, output logic err);
		int n;
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00},
			pwdata: {24'h000000, wd}};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 20);
		if (apb_rsp.pready !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: no pready", $time);
			results();
		end
		rd = apb_rsp.prdata[7:0];
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic reg_wr(input logic [5:0] idx, input logic [7:0] d);
		logic [7:0] r;
		logic e;
		xfer(1'b1, idx, d, r, e);
	endtask

	task automatic reg_rd(input logic [5:0] idx, input logic [7:0] exp);
		logic [7:0] r;
		logic e;
		xfer(1'b0, idx, 8'h00, r, e);
		`CHK(r, exp)
	endtask

	// samples on falling edges to stay clear of the register updates
	task automatic observe(input int n, output int ons, output int tog);
		logic s;
		ons = 0;
		tog = 0;
		@(negedge pclk);
		s = indicator_on;
		repeat (n) begin
			@(negedge pclk);
			ons += (indicator_on === 1'b1);
			tog += (indicator_on !== s);
			s = indicator_on;
		end
		@(posedge pclk);
	endtask

	task automatic half_period(output int h);
		logic s;
		int n;
		n = 0;
		@(negedge pclk);
		s = indicator_on;
		while (indicator_on === s && n < 200) begin
			@(negedge pclk);
			n++;
		end
		s = indicator_on;
		h = 0;
		while (indicator_on === s && h < 200) begin
			@(negedge pclk);
			h++;
		end
		if (n >= 200 || h >= 200) begin
			err_count++;
			$display("unexpected at %0t: indicator wave stuck", $time);
			results();
		end
		@(posedge pclk);
	endtask

	task automatic test_end(input string name);
		$display("test %s finished, mismatches so far %0d", name, err_count);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int h, ons, tog, nb;
		logic [7:0] r;
		logic e;
		logic [5:0] base;
		pmic_led_irq_pkg::buck_sense_type sv;
		presetn = 1'b0;
		ce = 1'b1;
		core_domain_reset = 1'b0;
		power_on_reset_n = 1'b1;
		host_reset_n = 1'b1;
		regs_off_pulse = 1'b0;
		apb_req = '0;
		buck_sense = '0;
		other_groups = '0;
		charger_state = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 12; i++) reg_rd(rst_idx[i], rst_val[i]);
		reg_wr(6'h06, 8'hFF);
		reg_rd(6'h06, 8'h00);
		reg_wr(6'h00, 8'hFF);
		reg_rd(6'h00, 8'h5A);
		reg_rd(6'h01, 8'h00);
		reg_rd(6'h02, 8'h11);
		xfer(1'b0, 6'h05, 8'h00, r, e);
		`CHK({e, r}, 9'h100)
		test_end("reset values");
		for (int k = 0; k < 3; k++) begin
			nb = (k == 2) ? 2 : 3;
			base = 6'h08 + 6'(3 * k);
			for (int b = 0; b < nb; b++) begin
				sv = 8'(1 << b) << ((k == 0) ? 5 : (k == 1) ? 2 : 0);
				buck_sense <= sv;
				repeat (3) @(posedge pclk);
				reg_rd(base, 8'(1 << b));
				reg_rd(base + 6'h02, 8'(1 << b));
				reg_rd(6'h06, 8'h00);
				reg_wr(base + 6'h01, 8'((nb == 3 ? 7 : 3) & ~(1 << b)));
				buck_sense <= '0;
				reg_rd(base, 8'(1 << b));
				reg_rd(6'h06, 8'(2 << b));
				`CHK(irq_group_summary, 8'(2 << b))
				reg_wr(base, 8'(1 << b));
				reg_rd(base, 8'h00);
				reg_rd(6'h06, 8'h00);
				reg_wr(base + 6'h01, (nb == 3) ? 8'h07 : 8'h03);
			end
		end
		for (int i = 0; i < 5; i++) begin
			other_groups <= 5'(1 << i);
			reg_rd(6'h06, grp_exp[i]);
			`CHK(irq_group_summary, grp_exp[i])
		end
		other_groups <= '0;
		test_end("interrupt groups");
		reg_wr(6'h1E, 8'h04);
		reg_rd(6'h1E, 8'h04);
		`CHK(indicator_drive_level, 2'h1)
		reg_wr(6'h1E, 8'hC0);
		reg_rd(6'h1E, 8'hC4);
		charger_state <= 3'b001;
		for (int c = 0; c < 4; c++) begin
			reg_wr(6'h1E, 8'h24 | 8'(c));
			half_period(h);
			`CHK(h, half_exp[c])
		end
		reg_wr(6'h1E, 8'h07);
		for (int p = 0; p < 2; p++) begin
			for (int s = 0; s < 3; s++) begin
				charger_state <= 3'b100 >> s;
				observe(24, ons, tog);
				if (s == 2) `CHK(ons, 0)
				else if (p == s) `CHK(ons, 24)
				else `CHK(tog > 0, 1'b1)
			end
			reg_wr(6'h1E, 8'h17);
		end
		test_end("indicator");
		reg_wr(6'h09, 8'h02);
		reg_wr(6'h1F, 8'hA5);
		regs_off_pulse <= 1'b1;
		@(posedge pclk);
		regs_off_pulse <= 1'b0;
		@(posedge pclk);
		reg_rd(6'h1F, 8'h00);
		reg_rd(6'h09, 8'h02);
		for (int i = 0; i < 2; i++) begin
			buck_sense <= 8'h20;
			repeat (3) @(posedge pclk);
			buck_sense <= '0;
			reg_rd(6'h08, 8'h01);
			reg_wr(6'h1F, 8'h5A);
			if (i == 0) power_on_reset_n <= 1'b0;
			else host_reset_n <= 1'b0;
			@(posedge pclk);
			power_on_reset_n <= 1'b1;
			host_reset_n <= 1'b1;
			@(posedge pclk);
			reg_rd(6'h08, 8'h00);
			reg_rd(6'h09, 8'h07);
			reg_rd(6'h1F, 8'h00);
			reg_rd(6'h1E, 8'h17);
		end
		core_domain_reset <= 1'b1;
		@(posedge pclk);
		core_domain_reset <= 1'b0;
		@(posedge pclk);
		reg_rd(6'h1E, 8'h00);
		`CHK(indicator_drive_level, 2'h0)
		test_end("resets");
		reg_wr(6'h1E, 8'h27);
		ce <= 1'b0;
		observe(12, ons, tog);
		`CHK(tog, 0)
		fork
			xfer(1'b0, 6'h1E, 8'h00, r, e);
			begin
				repeat (3) @(posedge pclk);
				`CHK(apb_rsp.pready, 1'b0)
				ce <= 1'b1;
			end
		join
		`CHK({e, r}, 9'h027)
		test_end("clock enable");
		results();
	end
endmodule
